// ==== hw/hic_ident_regs.v ====
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - 64-bit identifier in two words, quadlets three-four
// - identifier zero on power reset, kept soft
// - all-zero identifier is illegal, reported invalid
// - identifier written once: rom load or firmware
// - after load identifier is read-only
// - only quadlet reads in the rom 1K (page 1, offsets 0x400-0x7ff) served
// - low ten base bits read zero
// - memory address is base plus offset bits
// - first five quadlets answered locally
// - organization code read-only, field zero
// - flags readable at set and clear ports
// - set port ones set flags
// - clear port ones clear flags
// - byte-order flag picks data endianness
// - byte-order flag is always provided here
// - link power flag gates phy requests
// - both resets clear link power flag
// - link power alone does not give link-on
// - link-on needs power and enable both
`include "hic_defines.vh"
module hic_ident_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        soft_reset,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rom_load_valid,
    input  wire [63:0] rom_load_id,
    input  wire [31:0] hdr_q0,
    input  wire [31:0] opt_q2,
    input  wire        phy_req_in,
    output reg         phy_req_out_q,
    input  wire        rom_req_valid,
    input  wire [3:0]  rom_req_tcode,
    input  wire [47:0] rom_req_offset,
    output wire        rom_rsp_valid_q,
    output wire        rom_rsp_type_error_q,
    output wire        rom_rsp_local_q,
    output wire [31:0] rom_rsp_data_q,
    output wire        rom_rsp_mem_read_q,
    output wire [31:0] rom_rsp_mem_addr_q,
    output reg         keep_data_big_endian_q,
    output reg         link_power_flag_q,
    output reg         link_active_enable_q,
    output reg         node_link_on_q,
    output reg         id_valid_q
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [31:0] node_identifier_high_q;
    reg [31:0] node_identifier_low_q;
    reg        high_loaded_q;
    reg        low_loaded_q;
    reg [31:0] rom_base_q;
    wire       wr_en;
    wire       wr_setup;
    wire       rd_en;
    wire       id_locked;
    wire [31:0] flags_rd;
    wire [31:0] wmask;

    // writes commit at the access edge, where the master sees pready
    assign wr_en    = psel && penable && pready && pwrite;
    assign wr_setup = psel && !penable && pwrite;
    assign rd_en    = psel && !penable && !pwrite;
    // identifier locks when each word has been written, or by rom load
    assign id_locked = high_loaded_q && low_loaded_q;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign flags_rd = {12'h000, keep_data_big_endian_q, 1'b0,
                       link_active_enable_q, link_power_flag_q,
                       16'h0000};

    // ------------------------------------------------------------------
    // identifier: cleared only by power reset, single load
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            node_identifier_high_q <= 32'h0000_0000;
            node_identifier_low_q  <= 32'h0000_0000;
            high_loaded_q          <= 1'b0;
            low_loaded_q           <= 1'b0;
        end else if (!id_locked) begin
            // soft reset deliberately absent here: contents survive it
            if (rom_load_valid && !high_loaded_q && !low_loaded_q) begin
                node_identifier_high_q <= rom_load_id[63:32];
                node_identifier_low_q  <= rom_load_id[31:0];
                high_loaded_q          <= 1'b1;
                low_loaded_q           <= 1'b1;
            end else if (wr_en && paddr == `HIC_ADDR_ID_HIGH &&
                         !high_loaded_q) begin
                node_identifier_high_q <= pwdata;
                high_loaded_q          <= 1'b1;
            end else if (wr_en && paddr == `HIC_ADDR_ID_LOW &&
                         !low_loaded_q) begin
                node_identifier_low_q <= pwdata;
                low_loaded_q          <= 1'b1;
            end
        end
        // once locked every write falls through untouched
    end

    // zero identifier is flagged so firmware can refuse to go on bus
    always @(posedge clk) begin
        if (!rst_n) begin
            id_valid_q <= 1'b0;
        end else begin
            id_valid_q <= id_locked &&
                ({node_identifier_high_q, node_identifier_low_q}
                 != 64'h0);
        end
    end

    // ------------------------------------------------------------------
    // rom base mapping; soft reset leaves it, power reset loads zero
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            rom_base_q <= 32'h0000_0000;
        end else if (wr_en && paddr == `HIC_ADDR_ROM_BASE) begin
            rom_base_q <= ((rom_base_q & ~wmask) | (pwdata & wmask))
                          & `HIC_ROM_BASE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // controller flags through set and clear ports
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n || soft_reset) begin
            link_power_flag_q      <= 1'b0;
            link_active_enable_q   <= 1'b0;
            keep_data_big_endian_q <= 1'b0;
        end else if (wr_en && paddr == `HIC_ADDR_FLAGS_SET) begin
            // byte order is a real flag for the swap path
            if (pwdata[`HIC_FLAG_BIG_ENDIAN] && pstrb[2])
                keep_data_big_endian_q <= 1'b1;
            if (pwdata[`HIC_FLAG_LINK_ENABLE] && pstrb[2])
                link_active_enable_q <= 1'b1;
            if (pwdata[`HIC_FLAG_LINK_POWER] && pstrb[2])
                link_power_flag_q <= 1'b1;
        end else if (wr_en && paddr == `HIC_ADDR_FLAGS_CLEAR) begin
            if (pwdata[`HIC_FLAG_BIG_ENDIAN] && pstrb[2])
                keep_data_big_endian_q <= 1'b0;
            if (pwdata[`HIC_FLAG_LINK_ENABLE] && pstrb[2])
                link_active_enable_q <= 1'b0;
            if (pwdata[`HIC_FLAG_LINK_POWER] && pstrb[2])
                link_power_flag_q <= 1'b0;
        end
    end

    // link-on follows the flags one cycle later
    always @(posedge clk) begin
        if (!rst_n || soft_reset) begin
            node_link_on_q <= 1'b0;
            phy_req_out_q  <= 1'b0;
        end else begin
            // power alone is not enough
            node_link_on_q <= link_power_flag_q &&
                              link_active_enable_q;
            phy_req_out_q  <= phy_req_in && link_power_flag_q;
        end
    end

    // ------------------------------------------------------------------
    // apb slave: answers in the access phase after one setup cycle
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    `HIC_ADDR_ID_HIGH:     prdata <= node_identifier_high_q;
                    `HIC_ADDR_ID_LOW:      prdata <= node_identifier_low_q;
                    `HIC_ADDR_ROM_BASE:    prdata <= rom_base_q;
                    `HIC_ADDR_ORG_CODE:
                        prdata <= {`HIC_ORG_IMPL_BITS,
                                   `HIC_ORG_FIELD};
                    `HIC_ADDR_FLAGS_SET:   prdata <= flags_rd;
                    `HIC_ADDR_FLAGS_CLEAR: prdata <= flags_rd;
                    `HIC_ADDR_STATUS:
                        prdata <= {29'h0, node_link_on_q, id_valid_q,
                                   id_locked};
                    default:               pslverr <= 1'b1;
                endcase
            end else if (wr_setup) begin
                // writes to read-only words are dropped silently
                case (paddr)
                    `HIC_ADDR_ID_HIGH, `HIC_ADDR_ID_LOW,
                    `HIC_ADDR_ROM_BASE, `HIC_ADDR_ORG_CODE,
                    `HIC_ADDR_FLAGS_SET, `HIC_ADDR_FLAGS_CLEAR,
                    `HIC_ADDR_STATUS:      pslverr <= 1'b0;
                    default:               pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // remote config rom reads
    // ------------------------------------------------------------------
    hic_rom_lookup u_rom (
        .clk              (clk),
        .rst_n            (rst_n),
        .req_valid        (rom_req_valid),
        .req_tcode        (rom_req_tcode),
        .req_offset       (rom_req_offset),
        .rom_base         (rom_base_q),
        .hdr_q0           (hdr_q0),
        .opt_q2           (opt_q2),
        .node_id          ({node_identifier_high_q,
                            node_identifier_low_q}),
        .rsp_valid_q      (rom_rsp_valid_q),
        .rsp_type_error_q (rom_rsp_type_error_q),
        .rsp_local_q      (rom_rsp_local_q),
        .rsp_data_q       (rom_rsp_data_q),
        .rsp_mem_read_q   (rom_rsp_mem_read_q),
        .rsp_mem_addr_q   (rom_rsp_mem_addr_q)
    );
endmodule

// ==== hw/hic_defines.vh ====
`ifndef HIC_DEFINES_VH
`define HIC_DEFINES_VH

// ------------------------------------------------------------------
// register byte addresses on the apb bus
// ------------------------------------------------------------------
`define HIC_ADDR_ID_HIGH      12'h000
`define HIC_ADDR_ID_LOW       12'h004
`define HIC_ADDR_ROM_BASE     12'h008
`define HIC_ADDR_ORG_CODE     12'h00c
`define HIC_ADDR_FLAGS_SET    12'h010
`define HIC_ADDR_FLAGS_CLEAR  12'h014
`define HIC_ADDR_STATUS       12'h018

// ------------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------------
`define HIC_FLAG_BIG_ENDIAN   19
`define HIC_FLAG_LINK_ENABLE  17
`define HIC_FLAG_LINK_POWER   16
`define HIC_FLAG_MASK         32'h000b_0000
`define HIC_ROM_BASE_MASK     32'hffff_fc00
`define HIC_ORG_FIELD         24'h00_0000
`define HIC_ORG_IMPL_BITS     8'h00
`define HIC_ROM_HI            36'hffff_f000_0
`define HIC_ROM_PAGE          2'h1
`define HIC_HDR_QUADLETS      8'h05
`define HIC_TCODE_QREAD       4'h4
`define HIC_BUS_NAME          32'h3133_3934
`define HIC_STAT_ID_LOADED    0
`define HIC_STAT_ID_VALID     1
`define HIC_STAT_LINK_ON      2

`endif

// ==== hw/hic_rom_lookup.v ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// remote config rom quadlet decode and answer
// ------------------------------------------------------------------
`include "hic_defines.vh"
module hic_rom_lookup (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        req_valid,
    input  wire [3:0]  req_tcode,
    input  wire [47:0] req_offset,
    input  wire [31:0] rom_base,
    input  wire [31:0] hdr_q0,
    input  wire [31:0] opt_q2,
    input  wire [63:0] node_id,
    output reg         rsp_valid_q,
    output reg         rsp_type_error_q,
    output reg         rsp_local_q,
    output reg  [31:0] rsp_data_q,
    output reg         rsp_mem_read_q,
    output reg  [31:0] rsp_mem_addr_q
);
    wire       in_page;
    wire       is_qread;
    wire [7:0] quad_idx;
    reg [31:0] local_word;

    assign in_page  = (req_offset[47:12] == `HIC_ROM_HI) &&
                      (req_offset[11:10] == `HIC_ROM_PAGE);
    assign is_qread = (req_tcode == `HIC_TCODE_QREAD);
    assign quad_idx = req_offset[9:2];

    // first five quadlets come from local registers
    always @* begin
        case (quad_idx[2:0])
            3'h0: local_word = hdr_q0;
            3'h1: local_word = `HIC_BUS_NAME;
            3'h2: local_word = opt_q2;
            3'h3: local_word = node_id[63:32];
            default: local_word = node_id[31:0];
        endcase
    end

    // one-cycle registered answer; misaligned reads are refused too
    always @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid_q      <= 1'b0;
            rsp_type_error_q <= 1'b0;
            rsp_local_q      <= 1'b0;
            rsp_data_q       <= 32'h0000_0000;
            rsp_mem_read_q   <= 1'b0;
            rsp_mem_addr_q   <= 32'h0000_0000;
        end else begin
            rsp_valid_q      <= req_valid;
            rsp_type_error_q <= 1'b0;
            rsp_local_q      <= 1'b0;
            rsp_mem_read_q   <= 1'b0;
            if (req_valid) begin
                if (!in_page || !is_qread || req_offset[1:0] != 2'h0) begin
                    rsp_type_error_q <= 1'b1;
                end else if (quad_idx < `HIC_HDR_QUADLETS) begin
                    rsp_local_q <= 1'b1;
                    rsp_data_q  <= local_word;
                end else begin
                    rsp_mem_read_q <= 1'b1;
                    // base low bits are zero so this is an or of fields
                    rsp_mem_addr_q <= (rom_base & `HIC_ROM_BASE_MASK)
                                      + {22'h0, req_offset[9:0]};
                end
            end
        end
    end
endmodule

// ==== test/hic_ident_regs_sva.sv ====
`timescale 1ns/10ps
// ----
// answer, flag and remote read checks at the block ports
// ----
module hic_ident_regs_sva (
    input wire        clk,
    input wire        rst_n,
    input wire        soft_reset,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire        phy_req_out_q,
    input wire        rom_req_valid,
    input wire [3:0]  rom_req_tcode,
    input wire [47:0] rom_req_offset,
    input wire        rom_rsp_valid_q,
    input wire        rom_rsp_type_error_q,
    input wire        rom_rsp_local_q,
    input wire        rom_rsp_mem_read_q,
    input wire        link_power_flag_q,
    input wire        link_active_enable_q,
    input wire        node_link_on_q
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_n);
// soft reset wins over a flag write in the same cycle, so leave it out
// flag writes land at the access edge, when pready is seen high
wire        fw = psel && penable && pready && pwrite && pstrb[2]
                 && !soft_reset;
wire [11:0] lo = rom_req_offset[11:0];
wire        rd = rom_req_valid && rom_req_tcode == 4'h4 && lo[1:0] == 2'h0
                 && rom_req_offset[47:12] == 36'hffff_f000_0
                 && lo[11:10] == 2'h1;
AST_APB_ANSWER: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after setup");
AST_ROM_ANSWER: assert property (rom_req_valid |=> rom_rsp_valid_q &&
    $onehot({rom_rsp_type_error_q, rom_rsp_local_q, rom_rsp_mem_read_q}))
    else $error("remote read answer missing or ambiguous");
AST_ROM_REJECT: assert property (
    rom_req_valid && !rd |=> rom_rsp_type_error_q)
    else $error("illegal remote request not rejected");
AST_ROM_LOCAL: assert property (
    rd && lo <= 12'h410 |=> rom_rsp_local_q)
    else $error("header quadlet not answered locally");
AST_ROM_MAPPED: assert property (
    rd && lo > 12'h410 |=> rom_rsp_mem_read_q)
    else $error("rom quadlet not mapped to memory");
AST_FLAG_SET: assert property (
    fw && paddr == 12'h010 && pwdata[16] |=> link_power_flag_q)
    else $error("set port did not set link power");
AST_FLAG_CLEAR: assert property (
    fw && paddr == 12'h014 && pwdata[16] |=> !link_power_flag_q)
    else $error("clear port did not clear link power");
AST_SOFT_CLEAR: assert property (
    soft_reset |=> !link_power_flag_q && !node_link_on_q)
    else $error("soft reset left link power set");
AST_LINK_ON: assert property (
    link_power_flag_q && link_active_enable_q && !soft_reset
    |=> node_link_on_q) else $error("link on missing");
AST_POWER_ALONE: assert property (
    !link_active_enable_q |=> !node_link_on_q)
    else $error("link on without enable");
AST_PHY_GATE: assert property (
    !link_power_flag_q |=> !phy_req_out_q)
    else $error("phy request passed without power");
cover property (rd ##1 rom_rsp_mem_read_q);
cover property (rom_req_valid && !rd);
cover property (node_link_on_q);
endmodule
bind hic_ident_regs hic_ident_regs_sva hic_ident_regs_sva_i (.*);

// ==== test/hic_remote_node.sv ====
`timescale 1ns/10ps
// ----
// remote node issuing configuration rom requests
// ----
module hic_remote_node (
    input  wire         clk,
    output logic        rom_req_valid = 1'h0,
    output logic [3:0]  rom_req_tcode = 4'h0,
    output logic [47:0] rom_req_offset = 48'h0
);
// one request, taken at the next edge; released lines flip so a stale
// offset or code never looks like a fresh legal request
task automatic issue(input logic [3:0] t, input logic [47:0] o);
    rom_req_tcode <= t;
    rom_req_offset <= o;
    rom_req_valid <= 1'h1;
    @(posedge clk);
    rom_req_valid <= 1'h0;
    rom_req_offset <= ~o;
    rom_req_tcode <= ~t;
endtask
endmodule

// ==== test/hic_ident_regs_tb.sv ====
`timescale 1ns/10ps
module hic_ident_regs_tb;
// ----
// stimulus, design outputs and model state
// ----
logic        clk = 1'h0, rst_n = 1'h0, soft_reset = 1'h0, psel = 1'h0;
logic        penable = 1'h0, pwrite = 1'h0, phy_req_in = 1'h0;
logic        rom_load_valid = 1'h0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0, hdr_q0 = 32'h0, opt_q2 = 32'h0;
logic [3:0]  pstrb = 4'hf;
logic [63:0] rom_load_id = 64'h0;
wire  [31:0] prdata, rom_rsp_data_q, rom_rsp_mem_addr_q;
wire  [47:0] rom_req_offset;
wire  [3:0]  rom_req_tcode;
wire         pready, pslverr, phy_req_out_q, rom_req_valid, id_valid_q;
wire         rom_rsp_valid_q, rom_rsp_type_error_q, rom_rsp_local_q;
wire         rom_rsp_mem_read_q, keep_data_big_endian_q, node_link_on_q;
wire         link_power_flag_q, link_active_enable_q;
wire  [3:0]  kind = {rom_rsp_valid_q, rom_rsp_type_error_q,
                     rom_rsp_local_q, rom_rsp_mem_read_q};
int          bad_count, checks, cyc, i;
logic [31:0] m_id[2], m_base, m_fl, v;
bit          m_lk[2];
logic [11:0] offs[$] = '{12'h400, 12'h404, 12'h408, 12'h40c, 12'h410,
                         12'h414, 12'h7fc, 12'h800, 12'h3fc, 12'h402};
hic_ident_regs  hic_ident_regs_i (.*);
hic_remote_node hic_remote_node_i (.*);
always #2 clk = ~clk;
// the whole run needs about 380 cycles; a hang ends as a mismatch
always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
        bad_count++;
        stop_test;
    end
end
task automatic cmp(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
        bad_count++;
        $display("Error %0t %s", $time, m);
    end
endtask
task automatic stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
        $display("STATUS OK");
    end else begin
        $display("STATUS NOT OK");
    end
    $finish;
endtask
function automatic logic [31:0] mread(input logic [11:0] a);
    logic lk;
    lk = m_lk[0] & m_lk[1];
    case (a)
        12'h000, 12'h004: return m_id[a[2]];
        12'h008: return m_base;
        12'h010, 12'h014: return m_fl;
        12'h018: return {29'h0, m_fl[16] & m_fl[17],
                         lk & (m_id[0] != 0 || m_id[1] != 0), lk};
        default: return 32'h0;
    endcase
endfunction
// one transfer: request held until pready is sampled, model follows
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    // only the run timeout ends this wait
    while (pready !== 1'h1) @(posedge clk);
    cmp({31'h0, pslverr}, {31'h0, a > 12'h018}, "slave error");
    if (!w && a <= 12'h018) cmp(prdata, mread(a), "read data");
    if (w && a < 12'h008 && !m_lk[a[2]]) begin
        m_id[a[2]] = d;
        m_lk[a[2]] = 1'h1;
    end
    if (w && a == 12'h008) m_base = d & 32'hffff_fc00;
    if (w && a == 12'h010 && pstrb[2])
        m_fl = m_fl | (d & 32'h000b_0000);
    if (w && a == 12'h014 && pstrb[2])
        m_fl = m_fl & ~(d & 32'h000b_0000);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
endtask
// local rom load pulse; it only counts while neither word was written
task automatic load(input logic [63:0] d);
    rom_load_id <= d;
    rom_load_valid <= 1'h1;
    @(posedge clk);
    rom_load_valid <= 1'h0;
    if (!m_lk[0] && !m_lk[1]) begin
        m_id = '{d[63:32], d[31:0]};
        m_lk = '{1'h1, 1'h1};
    end
    @(posedge clk);
endtask
task automatic hw_reset;
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    m_id = '{32'h0, 32'h0};
    m_lk = '{1'h0, 1'h0};
    m_base = 32'h0;
    m_fl = 32'h0;
endtask
task automatic flags_chk;
    logic [31:0] s;
    s = mread(12'h018);
    repeat (2) @(posedge clk);
    cmp({link_power_flag_q, link_active_enable_q, keep_data_big_endian_q,
         node_link_on_q, phy_req_out_q, id_valid_q}, {m_fl[16], m_fl[17],
         m_fl[19], s[2], m_fl[16] & phy_req_in, s[1]}, "flag outputs");
endtask
// remote read; the one-cycle answer is looked at in its own cycle
task automatic rom(input logic [3:0] t, input logic [47:0] o);
    logic [31:0] e[5];
    e = '{hdr_q0, 32'h3133_3934, opt_q2, m_id[0], m_id[1]};
    hic_remote_node_i.issue(t, o);
    #1;
    if (t != 4'h4 || o[47:12] != 36'hffff_f000_0 || o[11:10] != 2'h1
        || o[1:0] != 2'h0) begin
        cmp(kind, 4'hc, "reject");
    end else if (o[11:0] <= 12'h410) begin
        cmp(kind, 4'ha, "local kind");
        cmp(rom_rsp_data_q, e[o[4:2]], "local data");
    end else begin
        cmp(kind, 4'h9, "mapped kind");
        cmp(rom_rsp_mem_addr_q, m_base + o[9:0], "mapped address");
    end
    @(posedge clk);
endtask
initial begin
    v = $urandom(32'h11edb37a);
    hw_reset;
    for (i = 0; i < 8; i++) apb(1'h0, 12'(i * 4), 32'h0);
    apb(1'h1, 12'h00c, $urandom);
    apb(1'h1, 12'h000, $urandom | 32'h1);
    apb(1'h1, 12'h004, $urandom);
    apb(1'h1, 12'h000, $urandom);
    load({$urandom, $urandom});
    apb(1'h1, 12'h008, $urandom);
    for (i = 0; i < 7; i++) apb(1'h0, 12'(i * 4), 32'h0);
    hdr_q0 <= $urandom;
    opt_q2 <= $urandom;
    phy_req_in <= 1'h1;
    // byte order only moves while the link is disabled
    for (i = 0; i < 24; i++) begin
        v = $urandom;
        if (m_fl[17]) v[19] = 1'h0;
        apb(1'h1, i[0] ? 12'h014 : 12'h010, v);
        apb(1'h0, i[0] ? 12'h010 : 12'h014, 32'h0);
        flags_chk;
    end
    foreach (offs[k]) rom(4'h4, {36'hffff_f000_0, offs[k]});
    for (i = 0; i < 16; i++) rom(4'(i), 48'hffff_f000_0418);
    rom(4'h4, 48'hffff_e000_0404);
    rom(4'h4, {36'hffff_f000_0, 2'h1, 8'($urandom), 2'h0});
    // a flag write without its byte lane enabled must not land
    pstrb <= 4'hb;
    apb(1'h1, 12'h010, 32'h0003_0000);
    pstrb <= 4'hf;
    flags_chk;
    apb(1'h1, 12'h010, 32'h0003_0000);
    soft_reset <= 1'h1;
    @(posedge clk);
    soft_reset <= 1'h0;
    m_fl = 32'h0;
    flags_chk;
    for (i = 0; i < 3; i++) apb(1'h0, 12'(i * 4), 32'h0);
    hw_reset;
    load({$urandom, $urandom | 32'h1});
    apb(1'h1, 12'h004, $urandom);
    for (i = 0; i < 7; i++) apb(1'h0, 12'(i * 4), 32'h0);
    hw_reset;
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h0, 12'h018, 32'h0);
    flags_chk;
    stop_test;
end
endmodule
